// ===== logic/dsl_core.sv
// serial load, input and dac registers of the dual dac front end
`timescale 1ns/100ps
`include "dsl_map.svh"
module dsl_core
  import dsl_pkg::*;
(
  input wire logic clk_i, // 10 mhz system clock
  input wire logic nrst_i, // sync reset, active low
  input wire logic sclk_i, // serial clock pin
  input wire logic select_n_i, // frame select pin, active low
  input wire logic serial_in_i, // serial data pin
  input wire logic load_strobe_n_i, // dac load pin, active low
  input wire logic preset_n_i, // preset pin, active low
  input wire logic preset_level_i, // 0 zero scale, 1 midscale
  input wire logic [7:0] addr_i, // register byte address
  input wire logic [31:0] wdata_i, // register write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  output logic [31:0] rdata_o, // read data, cycle after rd_i
  output logic [15:0] dac_a_o, // dac register a
  output logic [15:0] dac_b_o, // dac register b
  output logic frame_ready_o // fifo can take a frame
);
  logic [5:0] pin_s1;
  logic [5:0] pin_s2;
  logic [5:0] pin_s3;
  logic sclk_rise;
  logic sel_rise;
  logic sel_low;
  logic serial_in;
  logic ld_low;
  logic lvl;
  logic [1:0] por_cnt;
  logic preset_act;
  logic [`DSL_SR_W-1:0] sr;
  dsl_ctrl_t ctrl;
  dsl_frame_t frame_in;
  dsl_frame_t frame_out;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic pop;
  logic [`DSL_FIFO_AW:0] level;
  logic [15:0] in_a;
  logic [15:0] in_b;
  logic [15:0] pv;

  function automatic logic [15:0] preset_value(input logic narrow, input logic high);
    if (!high)
    begin
      return `DSL_ZERO;
    end
    return narrow ? `DSL_MID_NARROW : `DSL_MID_WIDE;
  endfunction

  function automatic dsl_frame_t frame_decode(input logic narrow,
                                              input logic [`DSL_SR_W-1:0] bits);
    dsl_frame_t f;
    f.addr = narrow ? bits[15:14] : bits[17:16];
    f.data = narrow ? (bits[15:0] & `DSL_NARROW_MASK) : bits[15:0];
    return f;
  endfunction

  // pins are asynchronous to clk_i: two flops before use, third for edges
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      pin_s1 <= `DSL_PIN_IDLE;
      pin_s2 <= `DSL_PIN_IDLE;
      pin_s3 <= `DSL_PIN_IDLE;
    end
    else
    begin
      pin_s1 <= {sclk_i, select_n_i, serial_in_i, load_strobe_n_i, preset_n_i,
                 preset_level_i};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  assign sclk_rise = pin_s2[`DSL_PIN_SCLK] && !pin_s3[`DSL_PIN_SCLK];
  assign sel_low = !pin_s2[`DSL_PIN_CS];
  assign sel_rise = pin_s2[`DSL_PIN_CS] && !pin_s3[`DSL_PIN_CS];
  assign serial_in = pin_s2[`DSL_PIN_SDI];
  assign ld_low = !pin_s2[`DSL_PIN_LD];
  assign lvl = pin_s2[`DSL_PIN_LVL];

  // power-on preset waits until the level pin has crossed the synchroniser
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      por_cnt <= `DSL_POR_CNT;
    end
    else if (por_cnt != 2'h0)
    begin
      por_cnt <= por_cnt - 2'h1;
    end
  end

  assign preset_act = (por_cnt != 2'h0) || !pin_s2[`DSL_PIN_PRE];
  assign pv = preset_value(ctrl.narrow, lvl);

  // serial shift register; longer frames simply push old bits out the top
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      sr <= '0;
    end
    else if (sel_low && sclk_rise)
    begin
      sr <= {sr[`DSL_SR_W-2:0], serial_in};
    end
  end

  assign frame_in = frame_decode(ctrl.narrow, sr);

  // frames queue here so software can hold input updates back
  dsl_fifo #(
    .W(`DSL_SR_W),
    .D(`DSL_FIFO_D),
    .AW(`DSL_FIFO_AW)
  ) u_fifo (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .in_valid_i(sel_rise),
    .in_ready_o(fifo_in_ready),
    .in_data_i(frame_in),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(pop),
    .out_data_o(frame_out),
    .level_o(level)
  );

  // drain stalls under hold or preset, so preset wins over queued frames
  assign pop = fifo_out_valid && !ctrl.hold && !preset_act;

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      frame_ready_o <= 1'b0;
    end
    else
    begin
      frame_ready_o <= fifo_in_ready;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      in_a <= `DSL_ZERO;
      in_b <= `DSL_ZERO;
    end
    else if (preset_act)
    begin
      in_a <= pv;
      in_b <= pv;
    end
    else if (pop)
    begin
      if (frame_out.addr[0])
      begin
        in_a <= frame_out.data;
      end
      if (frame_out.addr[1])
      begin
        in_b <= frame_out.data;
      end
    end
  end

  // strobe is a level, sampled every clock; no serial clock involved
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      dac_a_o <= `DSL_ZERO;
      dac_b_o <= `DSL_ZERO;
    end
    else if (preset_act)
    begin
      dac_a_o <= pv;
      dac_b_o <= pv;
    end
    else if (ld_low)
    begin
      dac_a_o <= in_a;
      dac_b_o <= in_b;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      ctrl <= '0;
    end
    else if (wr_i && addr_i == `DSL_OFS_CTRL)
    begin
      ctrl <= wdata_i[1:0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      rdata_o <= `DSL_RD_ZERO;
    end
    else if (rd_i)
    begin
      case (addr_i)
        `DSL_OFS_CTRL: rdata_o <= {30'h0, ctrl};
        `DSL_OFS_STAT: rdata_o <= {23'h0, level, preset_act, ld_low,
                                   fifo_out_valid, fifo_in_ready};
        `DSL_OFS_IN_A: rdata_o <= {16'h0, in_a};
        `DSL_OFS_IN_B: rdata_o <= {16'h0, in_b};
        `DSL_OFS_DAC_A: rdata_o <= {16'h0, dac_a_o};
        `DSL_OFS_DAC_B: rdata_o <= {16'h0, dac_b_o};
        default: rdata_o <= `DSL_RD_ZERO;
      endcase
    end
    else
    begin
      rdata_o <= `DSL_RD_ZERO;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  a_shift_takes_bit: assert property (
    sel_low && sclk_rise |=> sr[0] == $past(serial_in) && sr[17:1] == $past(sr[16:0]))
    else $error("shift register did not take serial bit");

  a_select_high_hold: assert property (
    !sel_low |=> $stable(sr))
    else $error("shift register moved while select high");

  a_commit_queues: assert property (
    sel_rise && fifo_in_ready && !pop |=> level == $past(level) + 1'b1)
    else $error("select rise did not queue the frame");

  a_dac_latched: assert property (
    !ld_low && !preset_act |=> $stable(dac_a_o) && $stable(dac_b_o))
    else $error("dac register changed without load strobe");

  a_dac_follows: assert property (
    ld_low && !preset_act |=> dac_a_o == $past(in_a) && dac_b_o == $past(in_b))
    else $error("dac register did not follow input register");

  a_preset_force: assert property (
    preset_act |=> in_a == $past(pv) && in_b == $past(pv) && dac_a_o == $past(pv)
      && dac_b_o == $past(pv))
    else $error("preset did not force registers");

  a_preset_zero: assert property (
    preset_act && !lvl |=> in_a == `DSL_ZERO && dac_a_o == `DSL_ZERO)
    else $error("zero preset wrong");

  a_preset_mid: assert property (
    preset_act && lvl && !ctrl.narrow |=> in_b == `DSL_MID_WIDE)
    else $error("midscale preset wrong");

  a_decode_skip_b: assert property (
    pop && frame_out.addr == `DSL_ADDR_A |=> $stable(in_b) && in_a == $past(frame_out.data))
    else $error("address a decode wrong");

  a_decode_none: assert property (
    pop && frame_out.addr == `DSL_ADDR_NONE |=> $stable(in_a) && $stable(in_b))
    else $error("address none changed a register");

  c_commit: cover property (sel_rise ##[1:20] pop);
  c_load: cover property (ld_low && !preset_act ##1 ld_low);
  c_preset_mid: cover property (preset_act && lvl ##1 !preset_act);
  c_fifo_full: cover property (!fifo_in_ready);
endmodule

// ===== common/dsl_map.svh
// constants for the dual dac serial load control block
// Functional notes
// - each serial clock rise shifts serial_in in
// - select high: serial clock edges ignored
// - select rising commits shift register to input
// - commits never touch the dac registers
// - load strobe low copies inputs to dacs
// - load strobe acts without serial clock edges
// - preset low forces all four registers
// - preset level low gives all zeros
// - preset level high gives midscale value
// - preset level also sets power-on value
// - frame is msb first: address, then data
// - only last frame-length bits are used
// - address 00 none, 01 a, 10 b, 11 both
`ifndef DSL_MAP_SVH
`define DSL_MAP_SVH
`define DSL_DATA_W 16
`define DSL_SR_W 18
`define DSL_FIFO_D 16
`define DSL_FIFO_AW 4
`define DSL_PIN_IDLE 6'h16
`define DSL_PIN_SCLK 5
`define DSL_PIN_CS 4
`define DSL_PIN_SDI 3
`define DSL_PIN_LD 2
`define DSL_PIN_PRE 1
`define DSL_PIN_LVL 0
`define DSL_POR_CNT 2'h3
`define DSL_ZERO 16'h0000
`define DSL_MID_WIDE 16'h8000
`define DSL_MID_NARROW 16'h2000
`define DSL_NARROW_MASK 16'h3fff
`define DSL_ADDR_NONE 2'h0
`define DSL_ADDR_A 2'h1
`define DSL_ADDR_B 2'h2
`define DSL_OFS_CTRL 8'h00
`define DSL_OFS_STAT 8'h04
`define DSL_OFS_IN_A 8'h08
`define DSL_OFS_IN_B 8'h0c
`define DSL_OFS_DAC_A 8'h10
`define DSL_OFS_DAC_B 8'h14
`define DSL_RD_ZERO 32'h0000_0000
`endif

// ===== common/dsl_pkg.sv
// types for the dual dac serial load control block
package dsl_pkg;
  typedef struct packed
  {
    logic [1:0] addr;
    logic [15:0] data;
  } dsl_frame_t;
  typedef struct packed
  {
    logic hold;
    logic narrow;
  } dsl_ctrl_t;
endpackage

// ===== logic/dsl_fifo.sv
// parameterised fifo between frame commit and input registers
`timescale 1ns/100ps
module dsl_fifo #(
  parameter int W = 18,
  parameter int D = 16,
  parameter int AW = 4
) (
  input wire logic clk_i, // system clock
  input wire logic nrst_i, // sync reset, active low
  input wire logic in_valid_i, // push request
  output logic in_ready_o, // not full
  input wire logic [W-1:0] in_data_i, // push word
  output logic out_valid_o, // not empty
  input wire logic out_ready_i, // pop request
  output logic [W-1:0] out_data_o, // head word
  output logic [AW:0] level_o // words held
);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready_o = (count < (AW+1)'(D));
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];
  assign level_o = count;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop)
      begin
        count <= count + 1'b1;
      end
      else if (pop && !push)
      begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// ===== verification/dsl_host.sv
// host side serial controller model driving the frame pins
`timescale 1ns/100ps
module dsl_host (
  input wire logic clk_i, // system clock
  output logic sclk_o, // serial clock, idles low
  output logic select_n_o, // frame select, active low
  output logic serial_o // serial data
);
  initial
  begin
    sclk_o = 1'b0;
    select_n_o = 1'b1;
    serial_o = 1'b0;
  end
  // idle data toggles so a stale bit never passes for a real one
  always @(posedge clk_i)
    if (select_n_o)
      serial_o <= ~serial_o;
  // msb first, each bit held 12 clocks, sclk high 4 and low 8, select low for the whole frame
  task automatic send(input logic [19:0] bits, input int n);
    @(posedge clk_i);
    select_n_o <= 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      repeat (4) @(posedge clk_i);
      serial_o <= bits[i];
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
    select_n_o <= 1'b1;
  endtask
  // clock pulses with select high, which the device must ignore
  task automatic stray(input int n);
    repeat (n)
    begin
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
  endtask
endmodule

// ===== verification/dsl_core_bench.sv
// self-checking bench for the dual dac serial load core
`timescale 1ns/100ps
module dsl_core_bench;
  import dsl_pkg::*;
  logic clk_i, nrst_i, load_n, preset_n, level, wr, rd, rd_seen;
  logic sclk, sel_n, serial_in, fready;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic [15:0] dac_a, dac_b, da, db;
  logic [31:0] exp_q[$];
  int error_cnt, checks, seed;
  dsl_host i_dsl_host (.clk_i(clk_i), .sclk_o(sclk), .select_n_o(sel_n), .serial_o(serial_in));
  dsl_core i_dsl_core (.clk_i(clk_i), .nrst_i(nrst_i), .sclk_i(sclk), .select_n_i(sel_n),
    .serial_in_i(serial_in), .load_strobe_n_i(load_n), .preset_n_i(preset_n),
    .preset_level_i(level), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .dac_a_o(dac_a), .dac_b_o(dac_b), .frame_ready_o(fready));
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    if (error_cnt == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_i);
    wr <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    rd <= 1'b1;
    addr <= a;
    exp_q.push_back(e);
    @(posedge clk_i);
    rd <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // read data stand only in the cycle after the strobe
  always @(negedge clk_i)
  begin
    if (rd_seen)
      cmp(rdata, exp_q.pop_front());
    rd_seen = rd;
  end
  initial
  begin
    seed = 32'h082767cc;
    {nrst_i, load_n, preset_n, level, wr, rd, rd_seen} = 7'b0111000;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    settle(12);
    nrst_i <= 1'b1;
    settle(8);
    cmp({31'h0, fready}, 32'h1);
    cmp({dac_a, dac_b}, 32'h8000_8000);
    da = 16'($random(seed));
    i_dsl_host.send({4'h1, da}, 18);
    settle(8);
    rd_reg(8'h08, {16'h0, da});
    cmp({16'h0, dac_a}, 32'h8000);
    db = 16'($random(seed));
    i_dsl_host.send({4'he, db}, 20);
    settle(8);
    rd_reg(8'h0c, {16'h0, db});
    i_dsl_host.send({4'h0, ~da}, 18);
    settle(8);
    rd_reg(8'h08, {16'h0, da});
    rd_reg(8'h0c, {16'h0, db});
    load_n <= 1'b0;
    settle(6);
    cmp({dac_a, dac_b}, {da, db});
    da = 16'($random(seed));
    i_dsl_host.send({4'h3, da}, 18);
    settle(8);
    cmp({dac_a, dac_b}, {da, da});
    load_n <= 1'b1;
    level <= 1'b0;
    preset_n <= 1'b0;
    settle(6);
    cmp({dac_a, dac_b}, 32'h0);
    rd_reg(8'h08, 32'h0);
    preset_n <= 1'b1;
    settle(4);
    i_dsl_host.stray(4);
    i_dsl_host.send(20'h0, 0);
    settle(8);
    rd_reg(8'h08, {16'h0, da});
    rd_reg(8'h0c, {16'h0, da});
    cmp({dac_a, dac_b}, 32'h0);
    // hold parks the committed frame in the fifo until cleared
    wr_reg(8'h00, 32'h2);
    rd_reg(8'h00, 32'h2);
    i_dsl_host.send({4'h1, ~da}, 18);
    settle(8);
    rd_reg(8'h04, 32'h13);
    rd_reg(8'h08, {16'h0, da});
    wr_reg(8'h00, 32'h1);
    rd_reg(8'h08, {16'h0, ~da});
    rd_reg(8'h10, 32'h0);
    db = 16'($random(seed));
    i_dsl_host.send({6'h2, db[13:0]}, 16);
    settle(8);
    rd_reg(8'h0c, {18'h0, db[13:0]});
    level <= 1'b1;
    preset_n <= 1'b0;
    settle(6);
    cmp({dac_a, dac_b}, 32'h2000_2000);
    preset_n <= 1'b1;
    settle(4);
    rd_reg(8'h20, 32'h0);
    summarize;
  end
  initial
  begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    summarize;
  end
endmodule
